// ---- src/cfd_config_decode.sv ----
// Configuration byte capture, readback and decode
`timescale 1ns/1ps
`default_nettype none
`include "cfd_defs.svh"

module cfd_config_decode
    import cfd_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Raw bytes from the nonvolatile array
    input wire logic [7:0] fuse_osc_i,
    input wire logic [7:0] fuse_supply_i,
    input wire logic [7:0] fuse_wdog_i,
    input wire logic [7:0] fuse_pin_i,
    input wire logic [7:0] fuse_debug_i,
    // Table read port
    input wire logic cfg_rd_i,
    input wire logic [21:0] cfg_addr_i,
    output logic [7:0] cfg_rdata_o,
    output logic cfg_rvalid_o,
    // Run-time controls from the core
    input wire logic software_brownout_enable_i,
    input wire logic software_watchdog_enable_i,
    input wire logic sleep_i,
    input wire logic stack_fault_i,
    input wire logic shared_clear_pin_i,
    // Static decoded settings
    output logic cfg_valid_o,
    output cfd_clk_s clk_cfg_o,
    output cfd_pwr_s pwr_cfg_o,
    output cfd_dbg_s dbg_cfg_o,
    // Run-time qualified controls
    output logic brownout_active_o,
    output logic watchdog_run_o,
    output logic stack_reset_o,
    output logic master_clear_n_o,
    output logic shared_clear_pin_o
);

    // ****************************************
    // Decode functions
    // ****************************************
    function automatic cfd_clk_s decode_osc(input logic [7:0] b);
        cfd_clk_s c;
        c.core_src = CFD_SRC_EXT_CLOCK;
        c.usb_src = CFD_SRC_EXT_CLOCK;
        c.pll_en = 1'b0;
        c.clock_output_function = 1'b0;
        c.clock_switchover_enable = b[`CFD_OSC_SWITCHOVER];
        c.failsafe_monitor_enable = b[`CFD_OSC_FAILSAFE];
        unique casez (b[`CFD_OSC_SEL_HI:0])
            4'b111?:
            begin
                c.core_src = CFD_SRC_FAST_CRYSTAL;
                c.pll_en = 1'b1;
            end
            4'b110?:
            begin
                c.core_src = CFD_SRC_FAST_CRYSTAL;
            end
            4'b1011:
            begin
                c.core_src = CFD_SRC_INTERNAL;
                c.usb_src = CFD_SRC_FAST_CRYSTAL;
            end
            4'b1010:
            begin
                c.core_src = CFD_SRC_INTERNAL;
                c.usb_src = CFD_SRC_STD_CRYSTAL;
            end
            4'b1001:
            begin
                c.core_src = CFD_SRC_INTERNAL;
                c.clock_output_function = 1'b1;
            end
            4'b1000:
            begin
                c.core_src = CFD_SRC_INTERNAL;
            end
            4'b0111:
            begin
                c.pll_en = 1'b1;
                c.clock_output_function = 1'b1;
            end
            4'b0110:
            begin
                c.pll_en = 1'b1;
            end
            4'b0101:
            begin
                c.clock_output_function = 1'b1;
            end
            4'b0100:
            begin
                c.clock_output_function = 1'b0;
            end
            4'b001?:
            begin
                c.core_src = CFD_SRC_STD_CRYSTAL;
                c.pll_en = 1'b1;
            end
            4'b000?:
            begin
                c.core_src = CFD_SRC_STD_CRYSTAL;
            end
        endcase
        // Shared source unless the core runs internally
        if (c.core_src != CFD_SRC_INTERNAL)
        begin
            c.usb_src = c.core_src;
        end
        return c;
    endfunction

    function automatic logic [15:0] postscale_ratio(input logic [3:0] ps);
        return 16'h0001 << ps;
    endfunction

    function automatic cfd_pwr_s decode_pwr(input logic [7:0] s, input logic [7:0] w, input logic [7:0] p);
        cfd_pwr_s r;
        r.usb_regulator_enable = s[`CFD_SUP_REGULATOR];
        r.brownout_level = s[`CFD_SUP_BOR_LVL_HI:`CFD_SUP_BOR_LVL_LO];
        r.brownout_mode = cfd_bor_mode_e'(s[`CFD_SUP_BOR_MODE_HI:`CFD_SUP_BOR_MODE_LO]);
        r.powerup_timer_en = ~s[`CFD_SUP_PWRUP_N];
        r.watchdog_always_on = w[`CFD_WD_ALWAYS_ON];
        r.watchdog_postscale = w[`CFD_WD_PS_HI:`CFD_WD_PS_LO];
        r.watchdog_ratio = postscale_ratio(w[`CFD_WD_PS_HI:`CFD_WD_PS_LO]);
        r.master_clear_pin_enable = p[`CFD_PIN_CLEAR];
        r.timer1_low_power_osc = p[`CFD_PIN_T1_LP];
        r.portb_analog_default = p[`CFD_PIN_PB_ANALOG];
        return r;
    endfunction

    function automatic cfd_dbg_s decode_dbg(input logic [7:0] d);
        cfd_dbg_s r;
        r.debugger_en = ~d[`CFD_DBG_DEBUGGER_N];
        r.extended_instructions_enable = d[`CFD_DBG_XINSTR];
        r.dedicated_debug_port_enable = d[`CFD_DBG_PORT];
        r.boot_block_2kw = d[`CFD_DBG_BOOT];
        r.single_supply_program_enable = d[`CFD_DBG_SINGLE_SUPPLY];
        r.stack_overflow_reset_enable = d[`CFD_DBG_STACK_RESET];
        return r;
    endfunction

    // ****************************************
    // Capture of the raw bytes
    // ****************************************
    logic loaded_r;
    logic [7:0] osc_r;
    logic [7:0] supply_r;
    logic [7:0] wdog_r;
    logic [7:0] pin_r;
    logic [7:0] debug_r;
    wire logic capture;
    wire logic [7:0] osc_nxt;
    wire logic [7:0] supply_nxt;
    wire logic [7:0] wdog_nxt;
    wire logic [7:0] pin_nxt;
    wire logic [7:0] debug_nxt;

    // Single capture on the first edge after reset release
    assign capture = ~loaded_r;
    assign osc_nxt = fuse_osc_i & `CFD_MASK_OSC;
    assign supply_nxt = fuse_supply_i & `CFD_MASK_SUPPLY;
    assign wdog_nxt = fuse_wdog_i & `CFD_MASK_WDOG;
    assign pin_nxt = fuse_pin_i & `CFD_MASK_PIN;
    assign debug_nxt = fuse_debug_i & `CFD_MASK_DEBUG;

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            loaded_r <= 1'b0;
        end
        else
        begin
            loaded_r <= 1'b1;
        end
    end

    // Raw bytes, masked so unimplemented bits stay zero
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            osc_r <= `CFD_RST_OSC;
            supply_r <= `CFD_RST_SUPPLY;
            wdog_r <= `CFD_RST_WDOG;
            pin_r <= `CFD_RST_PIN;
            debug_r <= `CFD_RST_DEBUG;
        end
        else if (capture)
        begin
            osc_r <= osc_nxt;
            supply_r <= supply_nxt;
            wdog_r <= wdog_nxt;
            pin_r <= pin_nxt;
            debug_r <= debug_nxt;
        end
    end

    // ****************************************
    // Registered decoded settings
    // ****************************************
    // Settings of an unprogrammed part, shown while in reset
    localparam cfd_clk_s CLK_CFG_RST = decode_osc(`CFD_RST_OSC);
    localparam cfd_pwr_s PWR_CFG_RST = decode_pwr(`CFD_RST_SUPPLY, `CFD_RST_WDOG, `CFD_RST_PIN);
    localparam cfd_dbg_s DBG_CFG_RST = decode_dbg(`CFD_RST_DEBUG);

    cfd_clk_s clk_cfg_r;
    cfd_pwr_s pwr_cfg_r;
    cfd_dbg_s dbg_cfg_r;
    wire cfd_clk_s clk_cfg_nxt;
    wire cfd_pwr_s pwr_cfg_nxt;
    wire cfd_dbg_s dbg_cfg_nxt;

    // Decode straight from the masked bytes being captured
    assign clk_cfg_nxt = decode_osc(osc_nxt);
    assign pwr_cfg_nxt = decode_pwr(supply_nxt, wdog_nxt, pin_nxt);
    assign dbg_cfg_nxt = decode_dbg(debug_nxt);

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            clk_cfg_r <= CLK_CFG_RST;
            pwr_cfg_r <= PWR_CFG_RST;
            dbg_cfg_r <= DBG_CFG_RST;
        end
        else if (capture)
        begin
            clk_cfg_r <= clk_cfg_nxt;
            pwr_cfg_r <= pwr_cfg_nxt;
            dbg_cfg_r <= dbg_cfg_nxt;
        end
    end

    assign cfg_valid_o = loaded_r;
    assign clk_cfg_o = clk_cfg_r;
    assign pwr_cfg_o = pwr_cfg_r;
    assign dbg_cfg_o = dbg_cfg_r;

    // ****************************************
    // Table readback
    // ****************************************
    logic [7:0] rdata_r;
    logic rvalid_r;
    wire logic hit_osc;
    wire logic hit_supply;
    wire logic hit_wdog;
    wire logic hit_pin;
    wire logic hit_debug;
    wire logic [7:0] rdata_nxt;
    wire logic [7:0] rdata_sel;

    // One hit per mapped byte address
    assign hit_osc = (cfg_addr_i == `CFD_ADDR_OSC);
    assign hit_supply = (cfg_addr_i == `CFD_ADDR_SUPPLY);
    assign hit_wdog = (cfg_addr_i == `CFD_ADDR_WDOG);
    assign hit_pin = (cfg_addr_i == `CFD_ADDR_PIN);
    assign hit_debug = (cfg_addr_i == `CFD_ADDR_DEBUG);

    // Unmapped addresses read as zero
    assign rdata_nxt = hit_osc ? osc_r :
                       hit_supply ? supply_r :
                       hit_wdog ? wdog_r :
                       hit_pin ? pin_r :
                       hit_debug ? debug_r : 8'h00;
    // Data bus idles at zero between reads
    assign rdata_sel = cfg_rd_i ? rdata_nxt : 8'h00;

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rdata_r <= 8'h00;
        end
        else
        begin
            rdata_r <= rdata_sel;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rvalid_r <= 1'b0;
        end
        else
        begin
            rvalid_r <= cfg_rd_i;
        end
    end

    assign cfg_rdata_o = rdata_r;
    assign cfg_rvalid_o = rvalid_r;

    // ****************************************
    // Run-time qualified controls
    // ****************************************
    logic bor_r;
    logic wdog_run_r;
    logic stk_r;
    logic clear_n_r;
    logic pin_in_r;
    wire logic bor_nxt;
    wire logic wdog_run_nxt;
    wire logic stk_nxt;
    wire logic clear_n_nxt;
    wire logic pin_in_nxt;

    assign bor_nxt = (pwr_cfg_r.brownout_mode == CFD_BOR_HW_ALWAYS) |
                     ((pwr_cfg_r.brownout_mode == CFD_BOR_HW_NO_SLEEP) & ~sleep_i) |
                     ((pwr_cfg_r.brownout_mode == CFD_BOR_SOFTWARE) & software_brownout_enable_i);
    assign wdog_run_nxt = pwr_cfg_r.watchdog_always_on | software_watchdog_enable_i;
    assign stk_nxt = stack_fault_i & dbg_cfg_r.stack_overflow_reset_enable;
    // Pin routes to clear or to port, never both
    assign clear_n_nxt = pwr_cfg_r.master_clear_pin_enable ? shared_clear_pin_i : 1'b1;
    assign pin_in_nxt = pwr_cfg_r.master_clear_pin_enable ? 1'b0 : shared_clear_pin_i;

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            bor_r <= 1'b0;
            wdog_run_r <= 1'b0;
            stk_r <= 1'b0;
            clear_n_r <= 1'b1;
            pin_in_r <= 1'b0;
        end
        else
        begin
            bor_r <= loaded_r & bor_nxt;
            wdog_run_r <= loaded_r & wdog_run_nxt;
            stk_r <= loaded_r & stk_nxt;
            clear_n_r <= clear_n_nxt;
            pin_in_r <= pin_in_nxt;
        end
    end

    assign brownout_active_o = bor_r;
    assign watchdog_run_o = wdog_run_r;
    assign stack_reset_o = stk_r;
    assign master_clear_n_o = clear_n_r;
    assign shared_clear_pin_o = pin_in_r;

endmodule

`default_nettype wire

// ---- common/cfd_defs.svh ----
// Offsets, field positions, masks and unprogrammed values of the configuration bytes
// Notes on behaviour
// - Unimplemented configuration bit positions read back as zero.
// - Oscillator byte bit 7 set enables internal/external clock switchover.
// - Oscillator byte bit 6 set enables the fail-safe clock monitor.
// - Select 111x is fast crystal with PLL, 110x fast crystal alone.
// - Select 001x is standard crystal with PLL, 000x standard crystal alone.
// - Codes 1011..1000 run core on internal oscillator; USB fed by named source.
// - Codes 0111/0110 external clock with PLL, 0101/0100 without; odd drives clock-out.
// - Core and USB share the crystal or external source; internal core with 1001/1000 keeps USB external.
// - Supply byte bit 5 set enables the USB voltage regulator.
// - Brown-out level 11 is the lowest trip point, 00 the highest.
// - Brown-out mode: 11 hardware, 10 hardware off in sleep, 01 software, 00 off.
// - Power-up timer bit 0 is active low and independent of brown-out.
// - Debug byte bit 5 set enables the dedicated debug port.
// - Watchdog postscale ratio is two to the power of the field.
// - Watchdog enable bit one runs it always, else software enable decides.
// - Pin byte bit 7 set makes shared pin master clear, digital input off.
// - Pin byte bit 2 set selects low-power Timer1 oscillator.
// - Pin byte bit 1 set makes low port-B pins analog after reset.
// - Debugger bit zero enables debugger and dedicates two port-B pins.
// - Debug byte bit 6 set enables extended instructions and indexed addressing.
// - Boot block size bit one gives 2 kW, zero gives 1 kW.
// - Stack-overflow reset bit one resets on stack full or underflow.
`ifndef CFD_DEFS_SVH
`define CFD_DEFS_SVH

// ****************************************
// Byte addresses
// ****************************************
`define CFD_ADDR_OSC 22'h300001
`define CFD_ADDR_SUPPLY 22'h300002
`define CFD_ADDR_WDOG 22'h300003
`define CFD_ADDR_PIN 22'h300005
`define CFD_ADDR_DEBUG 22'h300006

// ****************************************
// Implemented-bit masks
// ****************************************
`define CFD_MASK_OSC 8'hcf
`define CFD_MASK_SUPPLY 8'h3f
`define CFD_MASK_WDOG 8'h1f
`define CFD_MASK_PIN 8'h86
`define CFD_MASK_DEBUG 8'hed

// ****************************************
// Unprogrammed values
// ****************************************
`define CFD_RST_OSC 8'h07
`define CFD_RST_SUPPLY 8'h1f
`define CFD_RST_WDOG 8'h1f
`define CFD_RST_PIN 8'h82
`define CFD_RST_DEBUG 8'h85

// ****************************************
// Field positions
// ****************************************
`define CFD_OSC_SWITCHOVER 7
`define CFD_OSC_FAILSAFE 6
`define CFD_OSC_SEL_HI 3
`define CFD_SUP_REGULATOR 5
`define CFD_SUP_BOR_LVL_HI 4
`define CFD_SUP_BOR_LVL_LO 3
`define CFD_SUP_BOR_MODE_HI 2
`define CFD_SUP_BOR_MODE_LO 1
`define CFD_SUP_PWRUP_N 0
`define CFD_WD_PS_HI 4
`define CFD_WD_PS_LO 1
`define CFD_WD_ALWAYS_ON 0
`define CFD_PIN_CLEAR 7
`define CFD_PIN_T1_LP 2
`define CFD_PIN_PB_ANALOG 1
`define CFD_DBG_DEBUGGER_N 7
`define CFD_DBG_XINSTR 6
`define CFD_DBG_PORT 5
`define CFD_DBG_BOOT 3
`define CFD_DBG_SINGLE_SUPPLY 2
`define CFD_DBG_STACK_RESET 0

`endif

// ---- common/cfd_pkg.sv ----
// Types for the configuration decoder
package cfd_pkg;

    typedef enum logic [1:0] {
        CFD_SRC_INTERNAL,
        CFD_SRC_FAST_CRYSTAL,
        CFD_SRC_STD_CRYSTAL,
        CFD_SRC_EXT_CLOCK
    } cfd_src_e;

    typedef enum logic [1:0] {
        CFD_BOR_OFF,
        CFD_BOR_SOFTWARE,
        CFD_BOR_HW_NO_SLEEP,
        CFD_BOR_HW_ALWAYS
    } cfd_bor_mode_e;

    typedef struct packed {
        cfd_src_e core_src;
        cfd_src_e usb_src;
        logic pll_en;
        logic clock_output_function;
        logic clock_switchover_enable;
        logic failsafe_monitor_enable;
    } cfd_clk_s;

    typedef struct packed {
        logic usb_regulator_enable;
        logic [1:0] brownout_level;
        cfd_bor_mode_e brownout_mode;
        logic powerup_timer_en;
        logic watchdog_always_on;
        logic [3:0] watchdog_postscale;
        logic [15:0] watchdog_ratio;
        logic master_clear_pin_enable;
        logic timer1_low_power_osc;
        logic portb_analog_default;
    } cfd_pwr_s;

    typedef struct packed {
        logic debugger_en;
        logic extended_instructions_enable;
        logic dedicated_debug_port_enable;
        logic boot_block_2kw;
        logic single_supply_program_enable;
        logic stack_overflow_reset_enable;
    } cfd_dbg_s;

endpackage

// ---- dv/cfd_config_decode_checker.sv ----
// Concurrent checks on the configuration decoder ports
`timescale 1ns/1ps
`default_nettype none
`include "cfd_defs.svh"
module cfd_config_decode_checker
    import cfd_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Read port
    input wire logic cfg_rd_i,
    input wire logic [21:0] cfg_addr_i,
    input wire logic [7:0] cfg_rdata_o,
    input wire logic cfg_rvalid_o,
    // Run-time controls
    input wire logic software_brownout_enable_i,
    input wire logic software_watchdog_enable_i,
    input wire logic sleep_i,
    input wire logic stack_fault_i,
    input wire logic shared_clear_pin_i,
    // Decoded outputs
    input wire logic cfg_valid_o,
    input wire cfd_clk_s clk_cfg_o,
    input wire cfd_pwr_s pwr_cfg_o,
    input wire cfd_dbg_s dbg_cfg_o,
    input wire logic brownout_active_o,
    input wire logic watchdog_run_o,
    input wire logic stack_reset_o,
    input wire logic master_clear_n_o
);
    logic [7:0] msk;
    logic bor_exp;
    logic clear_exp;
    cfd_bor_mode_e mode;

    // Implemented bits of the addressed byte, none when unmapped
    assign msk = (cfg_addr_i == `CFD_ADDR_OSC) ? `CFD_MASK_OSC :
                 (cfg_addr_i == `CFD_ADDR_SUPPLY) ? `CFD_MASK_SUPPLY :
                 (cfg_addr_i == `CFD_ADDR_WDOG) ? `CFD_MASK_WDOG :
                 (cfg_addr_i == `CFD_ADDR_PIN) ? `CFD_MASK_PIN :
                 (cfg_addr_i == `CFD_ADDR_DEBUG) ? `CFD_MASK_DEBUG : 8'h00;
    assign mode = pwr_cfg_o.brownout_mode;
    assign bor_exp = (mode == CFD_BOR_HW_ALWAYS) || (mode == CFD_BOR_HW_NO_SLEEP && !sleep_i) ||
                     (mode == CFD_BOR_SOFTWARE && software_brownout_enable_i);
    assign clear_exp = pwr_cfg_o.master_clear_pin_enable ? shared_clear_pin_i : 1'b1;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    // ****************************************
    // Assertions
    // ****************************************
    a_valid_holds: assert property (cfg_valid_o |=> cfg_valid_o)
        else $error("valid flag dropped after capture");
    a_cfg_static: assert property (cfg_valid_o |=> $stable(clk_cfg_o) && $stable(pwr_cfg_o) && $stable(dbg_cfg_o))
        else $error("decoded settings changed after capture");
    a_unimpl_zero: assert property (cfg_rd_i |=> cfg_rvalid_o && (cfg_rdata_o & ~$past(msk)) == 8'h00)
        else $error("unimplemented bit read as one");
    a_read_idle: assert property (!cfg_rd_i |=> !cfg_rvalid_o && cfg_rdata_o == 8'h00)
        else $error("read data without a read");
    a_ratio_pow2: assert property (pwr_cfg_o.watchdog_ratio == (16'h1 << pwr_cfg_o.watchdog_postscale))
        else $error("watchdog ratio is not two to the field");
    a_stack_reset: assert property (cfg_valid_o |=> stack_reset_o == $past(dbg_cfg_o.stack_overflow_reset_enable && stack_fault_i))
        else $error("stack reset wrong");
    a_wdog_run: assert property (cfg_valid_o |=> watchdog_run_o == $past(pwr_cfg_o.watchdog_always_on || software_watchdog_enable_i))
        else $error("watchdog run wrong");
    a_bor_mode: assert property (cfg_valid_o |=> brownout_active_o == $past(bor_exp))
        else $error("brown-out enable wrong");
    a_clear_route: assert property (cfg_valid_o |=> master_clear_n_o == $past(clear_exp))
        else $error("master clear routing wrong");

    c_stack: cover property (stack_reset_o);
    c_read: cover property (cfg_rvalid_o && cfg_rdata_o != 8'h00);
    c_clear: cover property (cfg_valid_o && !master_clear_n_o);
    c_bor_sleep: cover property (cfg_valid_o && sleep_i && mode == CFD_BOR_HW_NO_SLEEP);
endmodule

bind cfd_config_decode cfd_config_decode_checker chk (.clk_i, .rst_n_i, .cfg_rd_i, .cfg_addr_i, .cfg_rdata_o,
    .cfg_rvalid_o, .software_brownout_enable_i, .software_watchdog_enable_i, .sleep_i, .stack_fault_i,
    .shared_clear_pin_i, .cfg_valid_o, .clk_cfg_o, .pwr_cfg_o, .dbg_cfg_o, .brownout_active_o,
    .watchdog_run_o, .stack_reset_o, .master_clear_n_o);
`default_nettype wire

// ---- dv/cfd_fuse_model.sv ----
// Nonvolatile array model feeding raw configuration bytes
`timescale 1ns/1ps
`default_nettype none
module cfd_fuse_model (
    // Clock and programmed contents
    input wire logic clk_i,
    input wire logic [39:0] prog_i,
    input wire logic scramble_i,
    // Bytes to the decoder
    output logic [39:0] fuse_o
);
    logic tog_r = 1'b0;

    always_ff @(posedge clk_i)
    begin
        tog_r <= ~tog_r;
    end
    // Once scrambled, lines alternate between the inverted and the programmed value each clock
    assign fuse_o = scramble_i ? (~prog_i ^ {40{tog_r}}) : prog_i;
endmodule
`default_nettype wire

// ---- dv/tb_config_fuse_decode.sv ----
// Self-checking bench for the configuration decoder
`timescale 1ns/1ps
`default_nettype none
`include "cfd_defs.svh"
module tb_config_fuse_decode;
    import cfd_pkg::*;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [39:0] prog = 40'h0;
    logic scr = 1'b0;
    logic [39:0] fuse;
    logic cfg_rd_i = 1'b0;
    logic [21:0] cfg_addr_i = 22'h000000;
    logic sbor = 1'b0, swdt = 1'b0, slp = 1'b0, flt = 1'b0, pin = 1'b0;
    logic [7:0] rdata;
    logic rvalid, valid, bor, wdr, stk, mcn, scp;
    cfd_clk_s ck;
    cfd_pwr_s pw;
    cfd_dbg_s db;
    logic [7:0] o, s, w, p, d;
    int fail_count = 0;
    int tests_run = 0;
    // Row: oscillator byte, then expected clock settings
    logic [15:0] rows [16] = '{16'h30a0, 16'h31a0, 16'h32a8, 16'h33a8, 16'hb4f2, 16'hb5f6, 16'hb6fa, 16'hb7fe,
                               16'h7831, 16'h7935, 16'h7a21, 16'h7b11, 16'hfc53, 16'hfd53, 16'hfe5b, 16'hff5b};

    cfd_fuse_model fm (.clk_i(clk_i), .prog_i(prog), .scramble_i(scr), .fuse_o(fuse));
    cfd_config_decode uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .fuse_osc_i(fuse[39:32]), .fuse_supply_i(fuse[31:24]),
        .fuse_wdog_i(fuse[23:16]), .fuse_pin_i(fuse[15:8]), .fuse_debug_i(fuse[7:0]), .cfg_rd_i(cfg_rd_i),
        .cfg_addr_i(cfg_addr_i), .cfg_rdata_o(rdata), .cfg_rvalid_o(rvalid), .software_brownout_enable_i(sbor),
        .software_watchdog_enable_i(swdt), .sleep_i(slp), .stack_fault_i(flt), .shared_clear_pin_i(pin),
        .cfg_valid_o(valid), .clk_cfg_o(ck), .pwr_cfg_o(pw), .dbg_cfg_o(db), .brownout_active_o(bor),
        .watchdog_run_o(wdr), .stack_reset_o(stk), .master_clear_n_o(mcn), .shared_clear_pin_o(scp));

    initial
    begin
        forever #12.5 clk_i = ~clk_i;
    end

    // ****************************************
    // Compare and closing tasks
    // ****************************************
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic close_out();
        if (fail_count == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    function automatic logic [7:0] exp_rd(input int k);
        case (k)
            1: return o & `CFD_MASK_OSC;
            2: return s & `CFD_MASK_SUPPLY;
            3: return w & `CFD_MASK_WDOG;
            5: return p & `CFD_MASK_PIN;
            6: return d & `CFD_MASK_DEBUG;
            default: return 8'h00;
        endcase
    endfunction

    // ****************************************
    // One row: program, reset, capture, scramble, check
    // ****************************************
    task automatic run_row(input logic [3:0] i, input logic [15:0] r);
        @(posedge clk_i);
        o = r[15:8];
        s = {i, ~i};
        w = {~i, i};
        p = {i, i};
        d = {~i, ~i};
        prog <= {o, s, w, p, d};
        scr <= 1'b0;
        rst_n_i <= 1'b0;
        sbor <= i[0];
        swdt <= i[1];
        slp <= i[2];
        flt <= i[3];
        pin <= i[1];
        @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        scr <= 1'b1;
        repeat (3) @(posedge clk_i);
        #1;
        cmp(valid, 1);
        cmp(ck, r[7:0]);
        cmp(pw, {s[5], s[4:3], s[2:1], ~s[0], w[0], w[4:1], 16'h1 << w[4:1], p[7], p[2], p[1]});
        cmp(db, {~d[7], d[6], d[5], d[3], d[2], d[0]});
        cmp(bor, s[2:1] == 2'b11 || (s[2:1] == 2'b10 && !i[2]) || (s[2:1] == 2'b01 && i[0]));
        cmp(wdr, w[0] | i[1]);
        cmp(stk, d[0] & i[3]);
        cmp(mcn, p[7] ? i[1] : 1'b1);
        cmp(scp, p[7] ? 1'b0 : i[1]);
        for (int k = 0; k <= 7; k++)
        begin
            @(posedge clk_i);
            cfg_rd_i <= (k < 7);
            cfg_addr_i <= 22'h300000 + 22'(k);
            #1;
            if (k > 0)
            begin
                cmp(rvalid, 1);
                cmp(rdata, exp_rd(k - 1));
            end
        end
        @(posedge clk_i);
        #1;
        cmp(rvalid, 0);
        cmp(rdata, 0);
    endtask

    initial
    begin
        repeat (10) @(posedge clk_i);
        #1;
        cmp(valid, 0);
        cmp(mcn, 1);
        cmp(ck, 8'hfc);
        for (int i = 0; i < 16; i++)
            run_row(i[3:0], rows[i]);
        // Mid-run reset: read on the capture edge, brown-out mode 10 in sleep
        @(posedge clk_i);
        prog <= {8'h07, 8'h15, 8'h00, 8'h00, 8'h85};
        scr <= 1'b0;
        slp <= 1'b1;
        rst_n_i <= 1'b0;
        @(posedge clk_i);
        rst_n_i <= 1'b1;
        cfg_rd_i <= 1'b1;
        cfg_addr_i <= `CFD_ADDR_SUPPLY;
        @(posedge clk_i);
        cfg_rd_i <= 1'b0;
        #1;
        cmp(rdata, `CFD_RST_SUPPLY);
        cmp(bor, 0);
        @(posedge clk_i);
        slp <= 1'b0;
        #1;
        cmp(valid, 1);
        cmp(bor, 0);
        cmp(rdata, 0);
        @(posedge clk_i);
        #1;
        cmp(bor, 1);
        close_out();
    end

    initial
    begin
        repeat (4000) @(posedge clk_i);
        fail_count++;
        close_out();
    end
endmodule
`default_nettype wire
